/* File: common/cmpdec_pkg.sv */
// Shared constants, types and helpers of the compare instruction decoder
package cmpdec_pkg;

	// ----------------------------------------------------------------
	// Widths and field positions
	// ----------------------------------------------------------------
	localparam int unsigned WORD_W = 16;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned RF_AW = 4;
	localparam int unsigned HI8_LSB = 8;
	localparam int unsigned LINE_LSB = 12;
	localparam int unsigned REGX_LSB = 9;
	localparam int unsigned OPM_LSB = 6;
	localparam int unsigned SIZE_LSB = 6;
	localparam int unsigned MODE_LSB = 3;
	localparam int unsigned REGY_LSB = 0;
	localparam int unsigned MEMORY_TO_MEMORY_COMPARE_OP_BIT = 8;

	// ----------------------------------------------------------------
	// Opcode patterns and field codes
	// ----------------------------------------------------------------
	localparam logic [7:0] CLR_OPHI = 8'h42;
	localparam logic [7:0] COMPARE_WITH_LITERAL_OP_OPHI = 8'h0c;
	localparam logic [3:0] CMP_LINE = 4'hb;
	localparam logic [1:0] SZ_BYTE = 2'h0;
	localparam logic [1:0] SZ_WORD = 2'h1;
	localparam logic [1:0] SZ_LONG = 2'h2;
	localparam logic [1:0] SZ_BAD = 2'h3;
	localparam logic [2:0] OPM_COMPARE_TO_POINTER_OP_W = 3'h3;
	localparam logic [2:0] OPM_COMPARE_TO_POINTER_OP_L = 3'h7;
	localparam logic [2:0] M_DREG = 3'h0;
	localparam logic [2:0] M_AREG = 3'h1;
	localparam logic [2:0] M_PINC = 3'h3;
	localparam logic [2:0] M_EXT = 3'h7;
	localparam logic [2:0] R_ABSL = 3'h1;
	localparam logic [2:0] R_PCX = 3'h3;
	localparam logic [2:0] R_IMM = 3'h4;
	localparam logic [1:0] EXT_ONE = 2'h1;
	localparam logic [1:0] EXT_LONG = 2'h2;
	localparam logic [DATA_W-1:0] RF_RESET = 32'h0000_0000;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_EXT = 3'b001,
		ST_ISSUE = 3'b011,
		ST_WAIT = 3'b010,
		ST_EXEC = 3'b110
	} cmpdec_state_t;

	typedef enum logic [1:0] {OP_CMP, OP_COMPARE_TO_POINTER_OP, OP_COMPARE_WITH_LITERAL_OP, OP_MEMORY_TO_MEMORY_COMPARE_OP} cmpdec_op_t;
	typedef enum logic [1:0] {K_REG, K_IMM, K_MEM, K_PINC} cmpdec_kind_t;

	typedef struct packed {
		logic [2:0] mode;
		logic [2:0] regn;
		logic [1:0] size;
		logic [DATA_W-1:0] addr;
	} cmpdec_ea_t;

	typedef struct packed {
		logic n;
		logic z;
		logic v;
		logic c;
	} cmpdec_flags_t;

	localparam cmpdec_flags_t CLR_FLAGS = 4'b0100;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [DATA_W-1:0] size_bytes(input logic [1:0] sz);
		return (sz == SZ_BYTE) ? 32'h1 : (sz == SZ_WORD) ? 32'h2 : 32'h4;
	endfunction

	function automatic logic [DATA_W-1:0] size_mask(input logic [1:0] sz);
		return (sz == SZ_BYTE) ? 32'h0000_00ff : (sz == SZ_WORD) ? 32'h0000_ffff : 32'hffff_ffff;
	endfunction

	// Data alterable: no pointer direct, no pc-relative, no literal
	function automatic logic ea_alterable(input logic [2:0] m, input logic [2:0] r);
		return (m != M_AREG) && ((m != M_EXT) || (r <= R_ABSL));
	endfunction

	// Data modes bar literal: pc-relative forms still allowed
	function automatic logic ea_data_noimm(input logic [2:0] m, input logic [2:0] r);
		return (m != M_AREG) && ((m != M_EXT) || (r <= R_PCX));
	endfunction

	function automatic logic ea_any(input logic [2:0] m, input logic [2:0] r);
		return (m != M_EXT) || (r <= R_IMM);
	endfunction

	function automatic cmpdec_flags_t cmp_flags(input logic [DATA_W-1:0] d, input logic [DATA_W-1:0] s,
			input logic [1:0] sz);
		logic [DATA_W:0] diff;
		logic [DATA_W-1:0] dm;
		logic [DATA_W-1:0] sm;
		logic [DATA_W-1:0] r;
		int unsigned msb;
		cmpdec_flags_t f;
		dm = d & size_mask(sz);
		sm = s & size_mask(sz);
		diff = {1'b0, dm} - {1'b0, sm};
		r = diff[DATA_W-1:0] & size_mask(sz);
		msb = (sz == SZ_BYTE) ? 7 : (sz == SZ_WORD) ? 15 : 31;
		f.n = r[msb];
		f.z = (r == '0);
		f.v = (dm[msb] ^ sm[msb]) & (dm[msb] ^ r[msb]);
		f.c = diff[DATA_W];
		return f;
	endfunction

endpackage

/* File: dv/cmpdec_dp_model.sv */
// Behavioural datapath that answers operand fetch requests after a set delay
`timescale 1ns/10ps
`default_nettype none
module cmpdec_dp_model #(
	parameter logic [31:0] MIX = 32'h0100_0193
) (
	// Clock
	input wire logic ref_clk_i,
	// Request side
	input wire logic req_i,
	input wire logic [31:0] addr_i,
	input wire logic [2:0] dly_i,
	// Answer side
	output logic valid_o,
	output logic [31:0] data_o
);
	logic busy_r = 1'b0;
	logic [2:0] cnt_r = 3'h0;
	logic [31:0] addr_r = 32'h0;
	logic valid_r = 1'b0;
	logic [31:0] data_r = 32'h0;
	assign valid_o = valid_r;
	assign data_o = data_r;
	// Data is a fixed mix of the address; between answers it flips every cycle
	always_ff @(posedge ref_clk_i) begin
		valid_r <= 1'b0;
		data_r <= ~data_r;
		if (req_i) begin
			busy_r <= 1'b1;
			cnt_r <= dly_i;
			addr_r <= addr_i;
		end else if (busy_r && cnt_r == 3'h0) begin
			busy_r <= 1'b0;
			valid_r <= 1'b1;
			data_r <= addr_r * MIX;
		end else if (busy_r) begin
			cnt_r <= cnt_r - 3'h1;
		end
	end
endmodule // cmpdec_dp_model
`default_nettype wire

/* File: dv/compare_instruction_decode_tb.sv */
// Self-checking bench of the compare family decoder
`timescale 1ns/10ps
`default_nettype none
module compare_instruction_decode_tb;
	localparam logic [31:0] MIX = 32'h0100_0193;
	localparam logic [16:0] LEG [0:10] = '{17'h14248, 17'h1427a, 17'h1427c, 17'h04280, 17'h04279, 17'h04258,
		17'h1b008, 17'h0b048, 17'h10c48, 17'h10c7c, 17'h00c7a};
	logic ref_clk_i, resetn_i, iw_valid_i, rf_wr_i, opnd_valid_i, iw_ready_o, opnd_req_o, clr_req_o;
	logic flags_we_o, done_o, illegal_o, res_ill, res_clr, res_we;
	logic [15:0] iw_data_i;
	logic [3:0] rf_wr_addr_i;
	logic [31:0] rf_wr_data_i, opnd_data_i, seed, vd, vs, lit;
	logic [2:0] dly;
	cmpdec_pkg::cmpdec_ea_t opnd_ea_o;
	cmpdec_pkg::cmpdec_flags_t flags_o, res_f;
	logic [31:0] addrs[$];
	int n_errors, checks_done, i, j, d, s, sz, nb;
	logic [15:0] op;

	cmpdec_top dut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .ce_i(1'b1), .iw_valid_i(iw_valid_i),
		.iw_data_i(iw_data_i), .iw_ready_o(iw_ready_o), .rf_wr_i(rf_wr_i), .rf_wr_addr_i(rf_wr_addr_i),
		.rf_wr_data_i(rf_wr_data_i), .opnd_req_o(opnd_req_o), .clr_req_o(clr_req_o), .opnd_ea_o(opnd_ea_o),
		.opnd_valid_i(opnd_valid_i), .opnd_data_i(opnd_data_i), .flags_o(flags_o), .flags_we_o(flags_we_o),
		.done_o(done_o), .illegal_o(illegal_o));
	cmpdec_dp_model #(.MIX(MIX)) dp (.ref_clk_i(ref_clk_i), .req_i(opnd_req_o), .addr_i(opnd_ea_o.addr),
		.dly_i(dly), .valid_o(opnd_valid_i), .data_o(opnd_data_i));

	initial begin
		ref_clk_i = 1'b0;
		forever #25 ref_clk_i = ~ref_clk_i;
	end
	always @(posedge ref_clk_i) if (opnd_req_o === 1'b1) addrs.push_back(opnd_ea_o.addr);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function int r8();
		return int'(rnd() & 32'h7);
	endfunction
	// Operand shifted to the top so one subtract serves all sizes
	function automatic logic [31:0] exp_f(input logic [31:0] dv, input logic [31:0] sv, input int z);
		logic [31:0] a, b, r;
		a = dv << (32 - 8 * (1 << z));
		b = sv << (32 - 8 * (1 << z));
		r = a - b;
		return {28'h0, r[31], r == 32'h0, (a[31] ^ b[31]) & (a[31] ^ r[31]), a < b};
	endfunction
	task end_sim();
		$display("checks_done %0d n_errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task tmo();
		n_errors++;
		$display("CHECK FAILED wait expected response seen none");
		end_sim();
	endtask
	task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task load(input int a, input logic [31:0] v);
		rf_wr_i <= 1'b1;
		rf_wr_addr_i <= 4'(a);
		rf_wr_data_i <= v;
		@(posedge ref_clk_i);
		rf_wr_i <= 1'b0;
		@(posedge ref_clk_i);
	endtask
	task put(input logic [15:0] w);
		int k;
		iw_valid_i <= 1'b1;
		iw_data_i <= w;
		for (k = 0; k < 60; k++) begin
			@(posedge ref_clk_i);
			if (iw_ready_o === 1'b1) break;
		end
		if (k == 60) tmo();
	endtask
	task run(input logic [15:0] w0, input logic [15:0] w1, input logic [15:0] w2, input int n);
		int k;
		addrs.delete();
		dly <= 3'(rnd());
		put(w0);
		if (n > 1) put(w1);
		if (n > 2) put(w2);
		iw_valid_i <= 1'b0;
		for (k = 0; k < 300; k++) begin
			@(posedge ref_clk_i);
			if (done_o === 1'b1 || illegal_o === 1'b1) break;
		end
		if (k == 300) tmo();
		res_f = flags_o;
		res_ill = illegal_o;
		res_clr = clr_req_o;
		res_we = flags_we_o;
		@(posedge ref_clk_i);
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		{resetn_i, iw_valid_i, rf_wr_i, iw_data_i, rf_wr_addr_i, rf_wr_data_i, dly} = '0;
		seed = 32'hfbe1;
		n_errors = 0;
		checks_done = 0;
		repeat (16) @(posedge ref_clk_i);
		resetn_i <= 1'b1;
		@(posedge ref_clk_i);
		for (i = 0; i < 9; i++) begin
			sz = i % 3;
			d = r8();
			s = (d + 1 + r8() % 7) % 8;
			vd = rnd();
			vs = (i == 0) ? vd : (i < 3) ? vd ^ (32'h1 << (8 * (1 << sz) - 1)) : rnd();
			load(d, vd);
			load(s, vs);
			for (j = 0; j < 2; j++) begin
				run(16'(32'hb000 | (d << 9) | (sz << 6) | s), 16'h0, 16'h0, 1);
				chk("reg compare flags", 32'(res_f), exp_f(vd, vs, sz));
			end
		end
		$display("test reg compare done");
		for (i = 0; i < 2; i++) begin
			d = r8();
			s = (d + 1) % 8;
			vd = rnd();
			vs = {16'h0, 1'b1, 15'(rnd())};
			load(8 + d, vd);
			load(8 * i + s, vs);
			op = (i == 0) ? 16'(32'hb0c0 | (d << 9) | s) : 16'(32'hb1c8 | (d << 9) | s);
			for (j = 0; j < 2; j++) begin
				run(op, 16'h0, 16'h0, 1);
				chk("pointer compare flags", 32'(res_f), exp_f(vd, (i == 0) ? {16'hffff, vs[15:0]} : vs, 2));
			end
		end
		$display("test pointer compare done");
		for (sz = 0; sz < 3; sz++) begin
			d = r8();
			vd = rnd();
			lit = rnd();
			load(d, vd);
			for (j = 0; j < 2; j++) begin
				op = (j == 0) ? 16'(32'h0c00 | (sz << 6) | d) : 16'(32'hb03c | (d << 9) | (sz << 6));
				if (sz == 2) run(op, lit[31:16], lit[15:0], 3);
				else run(op, lit[15:0], 16'h0, 2);
				chk("literal compare flags", 32'(res_f), exp_f(vd, lit, sz));
			end
		end
		$display("test literal compare done");
		load(0, rnd());
		load(8, rnd());
		for (i = 0; i < 11; i++) begin
			op = LEG[i][15:0];
			run(op, 16'h1234, 16'h0, (op[15:8] == 8'h0c && !LEG[i][16]) ? 2 : 1);
			chk("illegal", 32'(res_ill), 32'(LEG[i][16]));
			chk("flags strobe", 32'(res_we), 32'(!LEG[i][16]));
			if (op[15:8] == 8'h42) chk("clear store", 32'(res_clr), 32'(!LEG[i][16]));
		end
		$display("test legality done");
		for (sz = 0; sz < 3; sz++) begin
			d = r8();
			s = (d + 3) % 8;
			vd = rnd() & 32'hfff0_fff0;
			vs = rnd() & 32'hfff0_fff0;
			load(8 + d, vd);
			load(8 + s, vs);
			nb = 1 << sz;
			for (j = 0; j < 2; j++) begin
				run(16'(32'hb108 | (d << 9) | (sz << 6) | s), 16'h0, 16'h0, 1);
				chk("fetch count", 32'(addrs.size()), 32'h2);
				chk("dest ea", 32'({opnd_ea_o.mode, opnd_ea_o.regn, opnd_ea_o.size}), 32'({3'h3, 3'(d), 2'(sz)}));
				if (addrs.size() == 2) begin
					chk("source address", addrs[0], vs + 32'(j * nb));
					chk("dest address", addrs[1], vd + 32'(j * nb));
				end
				chk("memory compare flags", 32'(res_f), exp_f((vd + 32'(j * nb)) * MIX, (vs + 32'(j * nb)) * MIX, sz));
			end
		end
		$display("test memory compare done");
		end_sim();
	end
endmodule // compare_instruction_decode_tb
`default_nettype wire

/* File: src/cmpdec_regfile.sv */
// Register file of eight data and eight pointer registers
`timescale 1ns/10ps
`default_nettype none
module cmpdec_regfile (
	// Clock
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire logic ce_i,
	// Read port, data one cycle after the address
	input wire logic [cmpdec_pkg::RF_AW-1:0] rd_addr_i,
	output logic [cmpdec_pkg::DATA_W-1:0] rd_data_o,
	// Write port
	input wire logic wr_en_i,
	input wire logic [cmpdec_pkg::RF_AW-1:0] wr_addr_i,
	input wire logic [cmpdec_pkg::DATA_W-1:0] wr_data_i
);
	logic [cmpdec_pkg::DATA_W-1:0] mem_r [2**cmpdec_pkg::RF_AW];

	always_ff @(posedge ref_clk_i) begin
		if (ce_i && wr_en_i) begin
			mem_r[wr_addr_i] <= wr_data_i;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			rd_data_o <= cmpdec_pkg::RF_RESET;
		end else if (ce_i) begin
			rd_data_o <= mem_r[rd_addr_i];
		end
	end
endmodule // cmpdec_regfile
`default_nettype wire

/* File: src/cmpdec_top.sv */
// Compare family decoder and executor with its register file
// What this block does
// RULE_01 - The clear opcode is legal only with a data alterable destination, never pointer, pc-relative or literal.
// RULE_02 - The register compare subtracts the source from a data register for the flags and never writes it.
// RULE_03 - Every compare sets N, Z, V and C from the difference and leaves X alone.
// RULE_04 - The register compare names its data register in bits 11..9 and takes size from opmode 000/001/010.
// RULE_05 - The register compare takes any source mode, literal too, but pointer direct only at word or long.
// RULE_06 - The pointer compare subtracts the source from a pointer register for the flags and never writes it.
// RULE_07 - Pointer compare opmode 011 sign-extends a word source to 32 bits; opmode 111 is long.
// RULE_08 - The pointer compare takes any source mode, pointer direct at either size.
// RULE_09 - The literal compare subtracts a literal of the operation size from the destination without writing it.
// RULE_10 - The literal compare size field in bits 7..6 gives byte, word or long for 00, 01, 10.
// RULE_11 - The literal is the low byte of one word, one word, or two words high first.
// RULE_12 - The literal compare destination is any data mode but literal; pc-relative allowed, pointer direct not.
// RULE_13 - The memory compare fetches both operands by postincrement on two pointers and never writes memory.
// RULE_14 - The memory compare has its destination pointer in 11..9, a one in bit 8, size in 7..6, source in 2..0.
// RULE_15 - Each postincrement of the memory compare adds the operand size in bytes after its fetch.
`timescale 1ns/10ps
`default_nettype none
module cmpdec_top (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire logic ce_i,
	// Instruction word stream
	input wire logic iw_valid_i,
	input wire logic [cmpdec_pkg::WORD_W-1:0] iw_data_i,
	output logic iw_ready_o,
	// Register file load from the datapath
	input wire logic rf_wr_i,
	input wire logic [cmpdec_pkg::RF_AW-1:0] rf_wr_addr_i,
	input wire logic [cmpdec_pkg::DATA_W-1:0] rf_wr_data_i,
	// Operand fetch and clear store requests
	output logic opnd_req_o,
	output logic clr_req_o,
	output cmpdec_pkg::cmpdec_ea_t opnd_ea_o,
	input wire logic opnd_valid_i,
	input wire logic [cmpdec_pkg::DATA_W-1:0] opnd_data_i,
	// Results
	output cmpdec_pkg::cmpdec_flags_t flags_o,
	output logic flags_we_o,
	output logic done_o,
	output logic illegal_o
);
	// ----------------------------------------------------------------
	// Decode of the opcode word
	// ----------------------------------------------------------------
	logic acc;
	logic [2:0] f_mode, f_reg, f_rx, f_opm;
	logic [1:0] f_sz;
	logic d_legal, d_clear, d_sext;
	cmpdec_pkg::cmpdec_op_t d_op;
	cmpdec_pkg::cmpdec_kind_t d_src_k, d_dst_k;
	logic [1:0] d_alu_sz, d_src_sz, d_ext;
	logic [cmpdec_pkg::RF_AW-1:0] d_src_rn, d_dst_rn;

	cmpdec_pkg::cmpdec_state_t state_r, state_nxt;
	cmpdec_pkg::cmpdec_op_t op_r;
	cmpdec_pkg::cmpdec_kind_t src_k_r, dst_k_r, cur_k;
	logic [1:0] alu_sz_r, src_sz_r, ext_cnt_r;
	logic sext_r, slot_r, phase_r;
	logic [2:0] ea_mode_r, ea_reg_r;
	logic [cmpdec_pkg::RF_AW-1:0] src_rn_r, dst_rn_r, cur_rn;
	logic [cmpdec_pkg::DATA_W-1:0] src_val_r, dst_val_r, src_m, rf_rd_data;
	logic int_wr;
	logic [cmpdec_pkg::DATA_W-1:0] int_wr_data;

	assign acc = iw_valid_i && iw_ready_o;
	assign f_mode = iw_data_i[cmpdec_pkg::MODE_LSB +: 3];
	assign f_reg = iw_data_i[cmpdec_pkg::REGY_LSB +: 3];
	assign f_rx = iw_data_i[cmpdec_pkg::REGX_LSB +: 3]; // RULE_04
	assign f_opm = iw_data_i[cmpdec_pkg::OPM_LSB +: 3];
	assign f_sz = iw_data_i[cmpdec_pkg::SIZE_LSB +: 2]; // RULE_10

	always_comb begin
		d_legal = 1'b0;
		d_clear = 1'b0;
		d_sext = 1'b0;
		d_op = cmpdec_pkg::OP_CMP;
		d_alu_sz = f_sz;
		d_src_sz = f_sz;
		d_ext = '0;
		d_src_k = cmpdec_pkg::K_MEM;
		d_dst_k = cmpdec_pkg::K_REG;
		d_src_rn = {1'b0, f_reg};
		d_dst_rn = {1'b0, f_rx};
		if (f_mode == cmpdec_pkg::M_AREG) begin
			d_src_k = cmpdec_pkg::K_REG;
			d_src_rn = {1'b1, f_reg};
		end else if (f_mode == cmpdec_pkg::M_DREG) begin
			d_src_k = cmpdec_pkg::K_REG;
		end else if (f_mode == cmpdec_pkg::M_EXT && f_reg == cmpdec_pkg::R_IMM) begin
			d_src_k = cmpdec_pkg::K_IMM;
		end
		if (iw_data_i[cmpdec_pkg::HI8_LSB +: 8] == cmpdec_pkg::CLR_OPHI) begin
			d_clear = 1'b1;
			d_legal = (f_sz != cmpdec_pkg::SZ_BAD) && cmpdec_pkg::ea_alterable(f_mode, f_reg); // RULE_01
		end else if (iw_data_i[cmpdec_pkg::HI8_LSB +: 8] == cmpdec_pkg::COMPARE_WITH_LITERAL_OP_OPHI) begin
			d_op = cmpdec_pkg::OP_COMPARE_WITH_LITERAL_OP;
			d_legal = (f_sz != cmpdec_pkg::SZ_BAD) && cmpdec_pkg::ea_data_noimm(f_mode, f_reg); // RULE_12
			d_src_k = cmpdec_pkg::K_IMM; // RULE_09
			d_dst_k = (f_mode == cmpdec_pkg::M_DREG) ? cmpdec_pkg::K_REG : cmpdec_pkg::K_MEM;
			d_dst_rn = {1'b0, f_reg};
		end else if (iw_data_i[cmpdec_pkg::LINE_LSB +: 4] == cmpdec_pkg::CMP_LINE) begin
			if (f_opm == cmpdec_pkg::OPM_COMPARE_TO_POINTER_OP_W || f_opm == cmpdec_pkg::OPM_COMPARE_TO_POINTER_OP_L) begin
				d_op = cmpdec_pkg::OP_COMPARE_TO_POINTER_OP;
				d_legal = cmpdec_pkg::ea_any(f_mode, f_reg); // RULE_08
				d_sext = (f_opm == cmpdec_pkg::OPM_COMPARE_TO_POINTER_OP_W); // RULE_07
				d_src_sz = d_sext ? cmpdec_pkg::SZ_WORD : cmpdec_pkg::SZ_LONG;
				d_alu_sz = cmpdec_pkg::SZ_LONG;
				d_dst_rn = {1'b1, f_rx}; // RULE_06
			end else if (!f_opm[2]) begin
				d_alu_sz = f_opm[1:0]; // RULE_04
				d_src_sz = f_opm[1:0];
				d_legal = (f_opm[1:0] != cmpdec_pkg::SZ_BAD) && cmpdec_pkg::ea_any(f_mode, f_reg)
					&& !(f_mode == cmpdec_pkg::M_AREG && f_opm[1:0] == cmpdec_pkg::SZ_BYTE); // RULE_05
			end else if (f_mode == cmpdec_pkg::M_AREG && iw_data_i[cmpdec_pkg::MEMORY_TO_MEMORY_COMPARE_OP_BIT]) begin
				d_op = cmpdec_pkg::OP_MEMORY_TO_MEMORY_COMPARE_OP; // RULE_14
				d_legal = (f_sz != cmpdec_pkg::SZ_BAD);
				d_src_k = cmpdec_pkg::K_PINC;
				d_dst_k = cmpdec_pkg::K_PINC;
				d_dst_rn = {1'b1, f_rx};
			end
		end
		if (d_src_k == cmpdec_pkg::K_IMM) begin
			d_ext = (d_src_sz == cmpdec_pkg::SZ_LONG) ? cmpdec_pkg::EXT_LONG : cmpdec_pkg::EXT_ONE; // RULE_11
		end
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	assign cur_k = slot_r ? dst_k_r : src_k_r;
	assign cur_rn = slot_r ? dst_rn_r : src_rn_r;
	// Sign-extend a word source before the long compare
	assign src_m = sext_r ? {{(cmpdec_pkg::DATA_W - cmpdec_pkg::WORD_W){src_val_r[cmpdec_pkg::WORD_W-1]}},
		src_val_r[cmpdec_pkg::WORD_W-1:0]} : src_val_r; // RULE_07

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			cmpdec_pkg::ST_IDLE: begin
				if (acc && d_legal && !d_clear) begin
					state_nxt = (d_ext != '0) ? cmpdec_pkg::ST_EXT : cmpdec_pkg::ST_ISSUE;
				end
			end
			cmpdec_pkg::ST_EXT: begin
				if (acc && ext_cnt_r == cmpdec_pkg::EXT_ONE) begin
					state_nxt = cmpdec_pkg::ST_ISSUE;
				end
			end
			cmpdec_pkg::ST_ISSUE: begin
				if (cur_k != cmpdec_pkg::K_IMM) begin
					state_nxt = cmpdec_pkg::ST_WAIT;
				end
			end
			cmpdec_pkg::ST_WAIT: begin
				if (cur_k == cmpdec_pkg::K_REG || (opnd_valid_i && (cur_k == cmpdec_pkg::K_MEM || phase_r))) begin
					state_nxt = slot_r ? cmpdec_pkg::ST_EXEC : cmpdec_pkg::ST_ISSUE;
				end
			end
			cmpdec_pkg::ST_EXEC: state_nxt = cmpdec_pkg::ST_IDLE;
			default: state_nxt = cmpdec_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			state_r <= cmpdec_pkg::ST_IDLE;
			iw_ready_o <= 1'b0;
		end else if (ce_i) begin
			state_r <= state_nxt;
			iw_ready_o <= (state_nxt == cmpdec_pkg::ST_IDLE) || (state_nxt == cmpdec_pkg::ST_EXT);
		end
	end

	// Latch the decoded instruction and collect operands
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			op_r <= cmpdec_pkg::OP_CMP;
			src_k_r <= cmpdec_pkg::K_REG;
			dst_k_r <= cmpdec_pkg::K_REG;
			alu_sz_r <= cmpdec_pkg::SZ_BYTE;
			src_sz_r <= cmpdec_pkg::SZ_BYTE;
			ext_cnt_r <= '0;
			sext_r <= 1'b0;
			slot_r <= 1'b0;
			phase_r <= 1'b0;
			ea_mode_r <= '0;
			ea_reg_r <= '0;
			src_rn_r <= '0;
			dst_rn_r <= '0;
			src_val_r <= '0;
			dst_val_r <= '0;
		end else if (ce_i) begin
			if (state_r == cmpdec_pkg::ST_IDLE && acc) begin
				op_r <= d_op;
				src_k_r <= d_src_k;
				dst_k_r <= d_dst_k;
				alu_sz_r <= d_alu_sz;
				src_sz_r <= d_src_sz;
				ext_cnt_r <= d_ext;
				sext_r <= d_sext;
				slot_r <= 1'b0;
				phase_r <= 1'b0;
				ea_mode_r <= f_mode;
				ea_reg_r <= f_reg;
				src_rn_r <= d_src_rn;
				dst_rn_r <= d_dst_rn;
				src_val_r <= '0;
			end
			if (state_r == cmpdec_pkg::ST_EXT && acc) begin
				src_val_r <= {src_val_r[cmpdec_pkg::WORD_W-1:0], iw_data_i}; // RULE_11
				ext_cnt_r <= ext_cnt_r - cmpdec_pkg::EXT_ONE;
			end
			if (state_r == cmpdec_pkg::ST_ISSUE && cur_k == cmpdec_pkg::K_IMM) begin
				slot_r <= 1'b1;
			end
			if (state_r == cmpdec_pkg::ST_WAIT) begin
				if (cur_k == cmpdec_pkg::K_PINC && !phase_r) begin
					phase_r <= 1'b1;
				end else if (cur_k == cmpdec_pkg::K_REG || opnd_valid_i) begin
					phase_r <= 1'b0;
					slot_r <= 1'b1;
					if (slot_r) begin
						dst_val_r <= (cur_k == cmpdec_pkg::K_REG) ? rf_rd_data : opnd_data_i;
					end else begin
						src_val_r <= (cur_k == cmpdec_pkg::K_REG) ? rf_rd_data : opnd_data_i;
					end
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Requests and results
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			opnd_req_o <= 1'b0;
			clr_req_o <= 1'b0;
			opnd_ea_o <= '0;
			flags_o <= '0;
			flags_we_o <= 1'b0;
			done_o <= 1'b0;
			illegal_o <= 1'b0;
		end else if (ce_i) begin
			opnd_req_o <= 1'b0;
			clr_req_o <= 1'b0;
			flags_we_o <= 1'b0;
			done_o <= 1'b0;
			illegal_o <= 1'b0;
			if (state_r == cmpdec_pkg::ST_IDLE && acc) begin
				illegal_o <= !d_legal;
				if (d_legal && d_clear) begin
					clr_req_o <= 1'b1;
					opnd_ea_o <= '{mode: f_mode, regn: f_reg, size: f_sz, addr: '0};
					flags_o <= cmpdec_pkg::CLR_FLAGS;
					flags_we_o <= 1'b1;
					done_o <= 1'b1;
				end
			end
			if (state_r == cmpdec_pkg::ST_ISSUE && cur_k == cmpdec_pkg::K_MEM) begin
				opnd_req_o <= 1'b1;
				opnd_ea_o <= '{mode: ea_mode_r, regn: ea_reg_r, size: slot_r ? alu_sz_r : src_sz_r, addr: '0};
			end
			if (state_r == cmpdec_pkg::ST_WAIT && cur_k == cmpdec_pkg::K_PINC && !phase_r) begin
				opnd_req_o <= 1'b1; // RULE_13
				opnd_ea_o <= '{mode: cmpdec_pkg::M_PINC, regn: cur_rn[2:0], size: alu_sz_r, addr: rf_rd_data};
			end
			if (state_r == cmpdec_pkg::ST_EXEC) begin
				flags_o <= cmpdec_pkg::cmp_flags(dst_val_r, src_m, alu_sz_r); // RULE_03
				flags_we_o <= 1'b1;
				done_o <= 1'b1;
			end
		end
	end

	// Only the memory compare writes back, and only a pointer step
	assign int_wr = (state_r == cmpdec_pkg::ST_WAIT) && cur_k == cmpdec_pkg::K_PINC && !phase_r; // RULE_02 RULE_06 RULE_13
	assign int_wr_data = rf_rd_data + cmpdec_pkg::size_bytes(alu_sz_r); // RULE_15

	cmpdec_regfile u_rf (
		.ref_clk_i(ref_clk_i),
		.resetn_i(resetn_i),
		.ce_i(ce_i),
		.rd_addr_i(cur_rn),
		.rd_data_o(rf_rd_data),
		.wr_en_i(int_wr || rf_wr_i),
		.wr_addr_i(int_wr ? cur_rn : rf_wr_addr_i),
		.wr_data_i(int_wr ? int_wr_data : rf_wr_data_i)
	);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	logic [cmpdec_pkg::DATA_W-1:0] chk_dm, chk_sm;
	assign chk_dm = dst_val_r & cmpdec_pkg::size_mask(alu_sz_r);
	assign chk_sm = src_m & cmpdec_pkg::size_mask(alu_sz_r);
	logic idle_acc;
	assign idle_acc = ce_i && acc && state_r == cmpdec_pkg::ST_IDLE;

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!resetn_i);

	property p_clr_areg;
		idle_acc && iw_data_i[15:8] == cmpdec_pkg::CLR_OPHI && f_mode == cmpdec_pkg::M_AREG |=> illegal_o && !clr_req_o;
	endproperty
	a_clr_areg: assert property (p_clr_areg) else $error("clear accepted pointer direct"); // RULE_01
	property p_cmp_no_write;
		op_r == cmpdec_pkg::OP_CMP && state_r != cmpdec_pkg::ST_IDLE |-> !int_wr;
	endproperty
	a_cmp_no_write: assert property (p_cmp_no_write) else $error("register compare wrote back"); // RULE_02
	property p_borrow;
		ce_i && state_r == cmpdec_pkg::ST_EXEC |=> flags_we_o && done_o && flags_o.c == ($past(chk_dm) < $past(chk_sm))
			&& flags_o.z == ($past(chk_dm) == $past(chk_sm));
	endproperty
	a_borrow: assert property (p_borrow) else $error("carry or zero flag wrong"); // RULE_03
	property p_cmp_size;
		idle_acc && iw_data_i[15:12] == cmpdec_pkg::CMP_LINE && f_opm == {1'b0, cmpdec_pkg::SZ_WORD} |=>
			alu_sz_r == cmpdec_pkg::SZ_WORD && dst_rn_r == {1'b0, $past(f_rx)};
	endproperty
	a_cmp_size: assert property (p_cmp_size) else $error("register compare size or register wrong"); // RULE_04
	property p_cmp_areg_byte;
		idle_acc && iw_data_i[15:12] == cmpdec_pkg::CMP_LINE && f_opm == {1'b0, cmpdec_pkg::SZ_BYTE}
			&& f_mode == cmpdec_pkg::M_AREG |=> illegal_o;
	endproperty
	a_cmp_areg_byte: assert property (p_cmp_areg_byte) else $error("byte pointer source accepted"); // RULE_05
	property p_compare_to_pointer_op_no_write;
		op_r == cmpdec_pkg::OP_COMPARE_TO_POINTER_OP && state_r != cmpdec_pkg::ST_IDLE |-> !int_wr;
	endproperty
	a_compare_to_pointer_op_no_write: assert property (p_compare_to_pointer_op_no_write) else $error("pointer compare wrote back"); // RULE_06
	property p_compare_to_pointer_op_sext;
		state_r == cmpdec_pkg::ST_EXEC && sext_r |-> alu_sz_r == cmpdec_pkg::SZ_LONG
			&& src_m[cmpdec_pkg::DATA_W-1:cmpdec_pkg::WORD_W] == {(cmpdec_pkg::DATA_W - cmpdec_pkg::WORD_W){src_m[15]}};
	endproperty
	a_compare_to_pointer_op_sext: assert property (p_compare_to_pointer_op_sext) else $error("word source not sign-extended"); // RULE_07
	property p_compare_to_pointer_op_areg;
		idle_acc && iw_data_i[15:12] == cmpdec_pkg::CMP_LINE && f_opm[1:0] == cmpdec_pkg::OPM_COMPARE_TO_POINTER_OP_W[1:0]
			&& f_mode == cmpdec_pkg::M_AREG |=> !illegal_o ##1 state_r == cmpdec_pkg::ST_WAIT;
	endproperty
	a_compare_to_pointer_op_areg: assert property (p_compare_to_pointer_op_areg) else $error("pointer source refused"); // RULE_08
	property p_compare_with_literal_op_ext;
		idle_acc && iw_data_i[15:8] == cmpdec_pkg::COMPARE_WITH_LITERAL_OP_OPHI && f_sz == cmpdec_pkg::SZ_LONG && d_legal |=>
			state_r == cmpdec_pkg::ST_EXT && ext_cnt_r == cmpdec_pkg::EXT_LONG;
	endproperty
	a_compare_with_literal_op_ext: assert property (p_compare_with_literal_op_ext) else $error("long literal word count wrong"); // RULE_11
	property p_compare_with_literal_op_dst;
		idle_acc && iw_data_i[15:8] == cmpdec_pkg::COMPARE_WITH_LITERAL_OP_OPHI && f_mode == cmpdec_pkg::M_EXT && f_reg == cmpdec_pkg::R_IMM
			|=> illegal_o;
	endproperty
	a_compare_with_literal_op_dst: assert property (p_compare_with_literal_op_dst) else $error("literal destination accepted"); // RULE_12
	property p_memory_to_memory_compare_op_step;
		ce_i && int_wr |=> opnd_req_o && opnd_ea_o.mode == cmpdec_pkg::M_PINC
			&& u_rf.mem_r[$past(cur_rn)] == opnd_ea_o.addr + cmpdec_pkg::size_bytes(alu_sz_r);
	endproperty
	a_memory_to_memory_compare_op_step: assert property (p_memory_to_memory_compare_op_step) else $error("postincrement step wrong"); // RULE_15

	c_memory_to_memory_compare_op: cover property (op_r == cmpdec_pkg::OP_MEMORY_TO_MEMORY_COMPARE_OP && done_o);
	c_compare_with_literal_op_long: cover property (op_r == cmpdec_pkg::OP_COMPARE_WITH_LITERAL_OP && alu_sz_r == cmpdec_pkg::SZ_LONG && done_o);
	c_clear: cover property (clr_req_o);
	c_illegal: cover property (illegal_o);
endmodule // cmpdec_top
`default_nettype wire
